// File: bscr_cfg.svh
// Constants for the bus status, clock divider and soft reset block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef BSCR_CFG_SVH
`define BSCR_CFG_SVH
`define BSCR_ADDR_DIV      8'hcc
`define BSCR_ADDR_SRST     8'hcd
`define BSCR_DIV_RESET     8'h00
`define BSCR_SCALAR_HI     6
`define BSCR_SCALAR_LO     3
`define BSCR_EXP_HI        2
`define BSCR_EXP_LO        0
`define BSCR_SCL_FACTOR    5'h0a
`define BSCR_ST_BUS_ERR    8'h00
`define BSCR_ST_START      8'h08
`define BSCR_ST_RSTART     8'h10
`define BSCR_ST_AW_ACK     8'h18
`define BSCR_ST_AW_NACK    8'h20
`define BSCR_ST_MTX_ACK    8'h28
`define BSCR_ST_MTX_NACK   8'h30
`define BSCR_ST_ARB_LOST   8'h38
`define BSCR_ST_AR_ACK     8'h40
`define BSCR_ST_AR_NACK    8'h48
`define BSCR_ST_MRX_ACK    8'h50
`define BSCR_ST_MRX_NACK   8'h58
`define BSCR_ST_SW_ACK     8'h60
`define BSCR_ST_SW_ARB     8'h68
`define BSCR_ST_GC_ACK     8'h70
`define BSCR_ST_GC_ARB     8'h78
`define BSCR_ST_SRX_ACK    8'h80
`define BSCR_ST_SRX_NACK   8'h88
`define BSCR_ST_GRX_ACK    8'h90
`define BSCR_ST_GRX_NACK   8'h98
`define BSCR_ST_SLV_STOP   8'ha0
`define BSCR_ST_SR_ACK     8'ha8
`define BSCR_ST_SR_ARB     8'hb0
`define BSCR_ST_STX_ACK    8'hb8
`define BSCR_ST_STX_NACK   8'hc0
`define BSCR_ST_STX_LAST   8'hc8
`define BSCR_ST_A2W_ACK    8'hd0
`define BSCR_ST_A2W_NACK   8'hd8
`define BSCR_ST_IDLE       8'hf8
`define BSCR_FIFO_DEPTH    16
`endif

// File: bscr_event_src.sv
// Byte engine stand-in that pushes events into the status block.
// Assumes calls start at a falling clock edge.
`timescale 1ns/1ps
module bscr_event_src (
  input  wire logic             i_clk,
  input  wire logic             i_event_ready,
  output bscr_pkg::bscr_event_s o_event,
  output logic                  o_event_valid
);
  initial begin
    o_event       = '0;
    o_event_valid = 1'b0;
  end

  // Holds the event until an edge sees ready, scrambles the data, lets an edge pass.
  task automatic push(input bscr_pkg::bscr_event_e k, input logic a, input logic r,
                      output bit ok);
    ok            = 1'b0;
    o_event       = '{k, a, r};
    o_event_valid = 1'b1;
    for (int i = 0; i < 100 && !ok; i++) begin
      ok = i_event_ready;
      @(posedge i_clk);
      @(negedge i_clk);
    end
    o_event_valid = 1'b0;
    o_event       = ~o_event;
    @(negedge i_clk);
  endtask
endmodule

// File: bscr_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset already synchronised.
`timescale 1ns/1ps
module bscr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clear,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic [WIDTH-1:0]      o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = i_valid && o_ready;
  wire              pop  = o_valid && i_ready;

  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data  = mem[rd_ptr];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (i_clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: bscr_pkg.sv
// Types shared by the status, clock divider and soft reset block.
// Assumes no other package.
package bscr_pkg;
  typedef enum logic [4:0] {
    BSCR_EV_BUS_ERR, BSCR_EV_START, BSCR_EV_RSTART, BSCR_EV_ADDR_W, BSCR_EV_MTX,
    BSCR_EV_ARB_LOST, BSCR_EV_ADDR_R, BSCR_EV_MRX, BSCR_EV_SLV_W, BSCR_EV_GCALL,
    BSCR_EV_SRX, BSCR_EV_GRX, BSCR_EV_SLV_STOP, BSCR_EV_SLV_R, BSCR_EV_STX,
    BSCR_EV_STX_LAST, BSCR_EV_ADDR2_W
  } bscr_event_e;
  typedef struct packed {
    bscr_event_e kind;
    logic        ack;
    logic        after_arb;
  } bscr_event_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bscr_cpu_s;
  typedef enum logic [1:0] {BSCR_IDLE, BSCR_BUSY, BSCR_ERROR} bscr_state_e;
endpackage

// File: bscr_top.sv
// Status code register, clock divider register, sample and bus clock
// dividers, bus-error recovery and software reset of the two-wire controller.
// Assumes the byte engine reports events over a valid/ready port and that
// the control register logic supplies the flag clear and start/stop bits.
`timescale 1ns/1ps
`include "bscr_cfg.svh"
module bscr_top (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_cpu_wr,
  input  wire logic                 i_cpu_rd,
  input  wire logic [7:0]           i_cpu_addr,
  input  wire logic [7:0]           i_cpu_wdata,
  output logic [7:0]                o_cpu_rdata,
  output logic                      o_cpu_rvalid,
  input  wire bscr_pkg::bscr_event_s i_event,
  input  wire logic                 i_event_valid,
  output logic                      o_event_ready,
  input  wire logic                 i_illegal_cond,
  input  wire logic                 i_flag_clear,
  input  wire logic                 i_stop_request_bit,
  input  wire logic                 i_start_request_bit,
  output logic                      o_interrupt_flag_bit,
  output logic [7:0]                o_bus_state_code,
  output logic                      o_sample_tick,
  output logic                      o_scl_tick,
  output logic                      o_issue_start,
  output logic                      o_bus_idle,
  output logic                      o_engine_reset
);
  logic                  rst_meta;
  logic                  rst_sync;
  logic                  soft_rst;
  logic                  rst_n;
  logic [7:0]            bus_clock_divider;
  logic [7:0]            code;
  logic                  flag;
  bscr_pkg::bscr_state_e state;
  bscr_pkg::bscr_state_e next_state;
  logic [7:0]            samp_cnt;
  logic [7:0]            samp_lim;
  logic                  issue_start;
  bscr_pkg::bscr_event_s ev_data;
  logic                  ev_valid;
  logic                  ev_take;
  logic [7:0]            ev_code;

  // Reset release through two flip-flops.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  wire wr_div  = i_cpu_wr && (i_cpu_addr == `BSCR_ADDR_DIV);
  wire wr_srst = i_cpu_wr && (i_cpu_addr == `BSCR_ADDR_SRST);

  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_srst;
    end
  end
  assign rst_n          = rst_sync && !soft_rst;
  assign o_engine_reset = soft_rst;

  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      bus_clock_divider <= `BSCR_DIV_RESET;
    end else if (soft_rst) begin
      bus_clock_divider <= `BSCR_DIV_RESET;
    end else if (wr_div) begin
      bus_clock_divider <= {1'b0, i_cpu_wdata[`BSCR_SCALAR_HI:`BSCR_EXP_LO]};
    end
  end

  wire [3:0] scalar   = bus_clock_divider[`BSCR_SCALAR_HI:`BSCR_SCALAR_LO];
  wire [2:0] exponent = bus_clock_divider[`BSCR_EXP_HI:`BSCR_EXP_LO];

  assign samp_lim      = 8'((9'h001 << exponent) - 9'h001);
  assign o_sample_tick = (samp_cnt >= samp_lim);
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      samp_cnt <= 8'h00;
    end else if (soft_rst || o_sample_tick) begin
      samp_cnt <= 8'h00;
    end else begin
      samp_cnt <= samp_cnt + 8'h01;
    end
  end

  // bus clock prescale by 10(M+1).
  // The prescaler counts sample ticks; ten groups of M+1 ticks per bus-clock phase.
  wire [7:0] scl_lim = 8'(`BSCR_SCL_FACTOR * ({4'h0, scalar} + 8'h01) - 8'h01);
  logic [7:0] scl_div;
  assign o_scl_tick = o_sample_tick && (scl_div >= scl_lim);
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      scl_div <= 8'h00;
    end else if (soft_rst || o_scl_tick) begin
      scl_div <= 8'h00;
    end else if (o_sample_tick) begin
      scl_div <= scl_div + 8'h01;
    end
  end

  // Event queue from the byte engine.
  bscr_fifo #(
    .WIDTH ($bits(bscr_pkg::bscr_event_s)),
    .DEPTH (`BSCR_FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (rst_sync),
    .i_clear (soft_rst),
    .i_data  (i_event),
    .i_valid (i_event_valid),
    .o_ready (o_event_ready),
    .o_data  (ev_data),
    .o_valid (ev_valid),
    .i_ready (ev_take)
  );

  // An event is presented only while the flag is clear, so each code is seen.
  assign ev_take = ev_valid && !flag && !i_illegal_cond
                   && (state == bscr_pkg::BSCR_BUSY || state == bscr_pkg::BSCR_IDLE);

  // Status code selection for each event kind.
  always_comb begin
    ev_code = `BSCR_ST_IDLE;
    case (ev_data.kind)
      bscr_pkg::BSCR_EV_START:    ev_code = `BSCR_ST_START;
      bscr_pkg::BSCR_EV_RSTART:   ev_code = `BSCR_ST_RSTART;
      bscr_pkg::BSCR_EV_ADDR_W:   ev_code = ev_data.ack ? `BSCR_ST_AW_ACK : `BSCR_ST_AW_NACK;
      bscr_pkg::BSCR_EV_MTX:      ev_code = ev_data.ack ? `BSCR_ST_MTX_ACK : `BSCR_ST_MTX_NACK;
      bscr_pkg::BSCR_EV_ARB_LOST: ev_code = `BSCR_ST_ARB_LOST;
      bscr_pkg::BSCR_EV_ADDR_R:   ev_code = ev_data.ack ? `BSCR_ST_AR_ACK : `BSCR_ST_AR_NACK;
      bscr_pkg::BSCR_EV_MRX:      ev_code = ev_data.ack ? `BSCR_ST_MRX_ACK : `BSCR_ST_MRX_NACK;
      bscr_pkg::BSCR_EV_SLV_W:    ev_code = ev_data.after_arb ? `BSCR_ST_SW_ARB : `BSCR_ST_SW_ACK;
      bscr_pkg::BSCR_EV_GCALL:    ev_code = ev_data.after_arb ? `BSCR_ST_GC_ARB : `BSCR_ST_GC_ACK;
      bscr_pkg::BSCR_EV_SRX:      ev_code = ev_data.ack ? `BSCR_ST_SRX_ACK : `BSCR_ST_SRX_NACK;
      bscr_pkg::BSCR_EV_GRX:      ev_code = ev_data.ack ? `BSCR_ST_GRX_ACK : `BSCR_ST_GRX_NACK;
      bscr_pkg::BSCR_EV_SLV_STOP: ev_code = `BSCR_ST_SLV_STOP;
      bscr_pkg::BSCR_EV_SLV_R:    ev_code = ev_data.after_arb ? `BSCR_ST_SR_ARB : `BSCR_ST_SR_ACK;
      bscr_pkg::BSCR_EV_STX:      ev_code = ev_data.ack ? `BSCR_ST_STX_ACK : `BSCR_ST_STX_NACK;
      bscr_pkg::BSCR_EV_STX_LAST: ev_code = `BSCR_ST_STX_LAST;
      bscr_pkg::BSCR_EV_ADDR2_W:  ev_code = ev_data.ack ? `BSCR_ST_A2W_ACK : `BSCR_ST_A2W_NACK;
      bscr_pkg::BSCR_EV_BUS_ERR:  ev_code = `BSCR_ST_BUS_ERR;
      default:                    ev_code = `BSCR_ST_IDLE;
    endcase
  end

  // Error recovery state machine.
  wire recover = (state == bscr_pkg::BSCR_ERROR) && i_flag_clear && i_stop_request_bit;
  always_comb begin
    next_state = state;
    case (state)
      bscr_pkg::BSCR_IDLE: begin
        if (i_illegal_cond) begin
          next_state = bscr_pkg::BSCR_ERROR;
        end else if (ev_take) begin
          next_state = bscr_pkg::BSCR_BUSY;
        end
      end
      bscr_pkg::BSCR_BUSY: begin
        if (i_illegal_cond) begin
          next_state = bscr_pkg::BSCR_ERROR;
        end
      end
      bscr_pkg::BSCR_ERROR: begin
        if (recover) begin
          next_state = bscr_pkg::BSCR_IDLE;
        end
      end
      default: next_state = bscr_pkg::BSCR_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= bscr_pkg::BSCR_IDLE;
      issue_start <= 1'b0;
    end else begin
      state       <= next_state;
      issue_start <= recover && i_start_request_bit;
    end
  end

  // Status code and flag; a new code wins over a clear in the same cycle.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      code <= `BSCR_ST_IDLE;
      flag <= 1'b0;
    end else if (i_illegal_cond && state != bscr_pkg::BSCR_ERROR) begin
      code <= `BSCR_ST_BUS_ERR;
      flag <= 1'b1;
    end else if (ev_take) begin
      code <= ev_code;
      flag <= 1'b1;
    end else if (i_flag_clear) begin
      code <= `BSCR_ST_IDLE;
      flag <= 1'b0;
    end
  end

  wire [7:0] status_rd = {code[7:3], 3'b000};
  wire       rd_hit    = i_cpu_rd && (i_cpu_addr == `BSCR_ADDR_DIV);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cpu_rdata  <= 8'h00;
      o_cpu_rvalid <= 1'b0;
    end else begin
      o_cpu_rdata  <= rd_hit ? status_rd : 8'h00;
      o_cpu_rvalid <= i_cpu_rd;
    end
  end

  assign o_interrupt_flag_bit = flag;
  assign o_bus_state_code     = status_rd;
  assign o_issue_start        = issue_start;
  assign o_bus_idle           = (state == bscr_pkg::BSCR_IDLE);
endmodule

// File: bscr_top_props.sv
// Concurrent checks on the ports of the status, divider and soft reset block.
// Assumes it is bound into bscr_top and sees only that module's ports.
`timescale 1ns/1ps
module bscr_top_props (
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_cpu_wr,
  input wire logic       i_cpu_rd,
  input wire logic [7:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  input wire logic [7:0] o_cpu_rdata,
  input wire logic       i_illegal_cond,
  input wire logic       i_flag_clear,
  input wire logic       i_stop_request_bit,
  input wire logic       i_start_request_bit,
  input wire logic       o_interrupt_flag_bit,
  input wire logic [7:0] o_bus_state_code,
  input wire logic       o_sample_tick,
  input wire logic       o_scl_tick,
  input wire logic       o_issue_start,
  input wire logic       o_bus_idle,
  input wire logic       o_engine_reset
);
  logic [6:0]  div;
  logic [15:0] s_gap;
  logic [15:0] c_gap;
  logic [1:0]  s_seen;
  logic [1:0]  c_seen;
  wire         div_wr  = i_cpu_wr && i_cpu_addr == 8'hcc;
  wire         srst_wr = i_cpu_wr && i_cpu_addr == 8'hcd;
  wire  [15:0] scl_len = (16'h000a * (16'(div[6:3]) + 16'h0001)) << div[2:0];

  // Gaps are judged only from the third tick after a divider change.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div    <= 7'h00;
      s_seen <= 2'h0;
      c_seen <= 2'h0;
    end else if (div_wr || srst_wr) begin
      div    <= srst_wr ? 7'h00 : i_cpu_wdata[6:0];
      s_seen <= 2'h0;
      c_seen <= 2'h0;
    end else begin
      s_seen <= s_seen + {1'b0, o_sample_tick && s_seen != 2'h2};
      c_seen <= c_seen + {1'b0, o_scl_tick && c_seen != 2'h2};
    end
  end
  always_ff @(posedge i_clk) begin
    s_gap <= o_sample_tick ? 16'h0001 : s_gap + 16'h0001;
    c_gap <= o_scl_tick ? 16'h0001 : c_gap + 16'h0001;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence err_clear_s;
    o_bus_state_code == 8'h00 && o_interrupt_flag_bit && i_flag_clear
      && i_stop_request_bit && !i_illegal_cond && !srst_wr;
  endsequence

  illegal_entry_a:
    assert property (i_illegal_cond && !srst_wr |=> o_bus_state_code == 8'h00
      && o_interrupt_flag_bit) else $error("no bus error code");
  error_exit_a:
    assert property (err_clear_s |=> o_bus_state_code == 8'hf8 && o_bus_idle
      && !o_interrupt_flag_bit) else $error("bus error not left");
  restart_issue_a:
    assert property (err_clear_s |=> o_issue_start == $past(i_start_request_bit))
      else $error("start after recovery wrong");
  idle_no_flag_a:
    assert property ((o_bus_state_code == 8'hf8) == !o_interrupt_flag_bit)
      else $error("idle code and flag disagree");
  sample_rate_a:
    assert property (o_sample_tick && s_seen == 2'h2 |-> s_gap == (16'h0001 << div[2:0]))
      else $error("sample tick spacing wrong");
  scl_rate_a:
    assert property (o_scl_tick && c_seen == 2'h2 |-> c_gap == scl_len)
      else $error("bus clock tick spacing wrong");
  soft_reset_a:
    assert property (srst_wr |=> o_engine_reset && o_bus_state_code == 8'hf8
      && !o_interrupt_flag_bit && o_bus_idle) else $error("soft reset missed");
  flag_holds_a:
    assert property (o_interrupt_flag_bit && !i_flag_clear && !i_illegal_cond && !srst_wr
      |=> o_interrupt_flag_bit && $stable(o_bus_state_code)) else $error("flag dropped");
  clear_code_a:
    assert property (o_interrupt_flag_bit && i_flag_clear && o_bus_state_code != 8'h00
      && !i_illegal_cond && !srst_wr |=> o_bus_state_code == 8'hf8) else $error("no F8");
  status_read_a:
    assert property (i_cpu_rd && i_cpu_addr == 8'hcc |=> o_cpu_rdata
      == {$past(o_bus_state_code[7:3]), 3'h0}) else $error("status read wrong");
endmodule

bind bscr_top bscr_top_props u_props (.*);

// File: tb_bscr_top.sv
// Self-checking bench for the status, divider and soft reset block.
// Assumes the event source model and the bound checker.
`timescale 1ns/1ps
module tb_bscr_top;
  logic                  i_clk = 1'b0;
  logic                  i_resetn = 1'b0;
  logic                  i_cpu_wr = 1'b0;
  logic                  i_cpu_rd = 1'b0;
  logic [7:0]            i_cpu_addr = 8'h00;
  logic [7:0]            i_cpu_wdata = 8'h00;
  logic                  i_illegal_cond = 1'b0;
  logic                  i_flag_clear = 1'b0;
  logic                  i_stop_request_bit = 1'b0;
  logic                  i_start_request_bit = 1'b0;
  bscr_pkg::bscr_event_s i_event;
  logic                  i_event_valid;
  logic [7:0]            o_cpu_rdata;
  logic [7:0]            o_bus_state_code;
  logic                  o_cpu_rvalid;
  logic                  o_event_ready;
  logic                  o_interrupt_flag_bit;
  logic                  o_sample_tick;
  logic                  o_scl_tick;
  logic                  o_issue_start;
  logic                  o_bus_idle;
  logic                  o_engine_reset;
  int                    n_mismatch = 0;
  int                    n_checks = 0;
  int                    g;
  bit                    ok;
  logic                  tsel = 1'b0;
  logic [7:0]            rd_v;
  logic [7:0]            exp_c;
  logic [16:0]           ack_kinds = 17'h14cd8;
  logic [16:0]           arb_kinds = 17'h02300;
  logic [7:0]            base [17] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h28, 8'h38, 8'h40,
                                       8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'ha0, 8'ha8,
                                       8'hb8, 8'hc8, 8'hd0};
  wire                   tick = tsel ? o_scl_tick : o_sample_tick;

  always #50 i_clk = ~i_clk;

  bscr_top dut (.*);
  bscr_event_src src (
    .i_clk         (i_clk),
    .i_event_ready (o_event_ready),
    .o_event       (i_event),
    .o_event_valid (i_event_valid)
  );

  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    chk(8'h00, 8'h01);
    print_verdict();
  endtask

  task automatic push_ev(input bscr_pkg::bscr_event_e k, input logic a, input logic r);
    src.push(k, a, r, ok);
    if (ok !== 1'b1) begin
      give_up();
    end
  endtask

  task automatic cpu_rd(input logic [7:0] a, output logic [7:0] d);
    i_cpu_rd   = 1'b1;
    i_cpu_addr = a;
    @(negedge i_clk);
    i_cpu_rd = 1'b0;
    d        = o_cpu_rdata;
    chk({7'h0, o_cpu_rvalid}, 8'h01);
  endtask

  task automatic cpu_wr(input logic [7:0] a, input logic [7:0] d);
    i_cpu_wr    = 1'b1;
    i_cpu_addr  = a;
    i_cpu_wdata = d;
    @(negedge i_clk);
    i_cpu_wr = 1'b0;
  endtask

  task automatic clr();
    i_flag_clear = 1'b1;
    @(negedge i_clk);
    i_flag_clear = 1'b0;
  endtask

  task automatic wait_flag();
    for (int i = 0; i < 50 && o_interrupt_flag_bit !== 1'b1; i++) @(negedge i_clk);
    if (o_interrupt_flag_bit !== 1'b1) begin
      give_up();
    end
  endtask

  task automatic expect_code(input logic [7:0] e);
    chk(o_bus_state_code, e);
    chk({7'h0, o_interrupt_flag_bit}, {7'h0, e != 8'hf8});
    cpu_rd(8'hcc, rd_v);
    chk(rd_v, {e[7:3], 3'h0});
  endtask

  task automatic tick_gap();
    for (g = 0; g < 999 && tick !== 1'b1; g++) @(negedge i_clk);
    if (tick !== 1'b1) begin
      give_up();
    end
    for (g = 1; g < 999; g++) begin
      @(negedge i_clk);
      if (tick === 1'b1) break;
    end
    if (g >= 999) begin
      give_up();
    end
  endtask

  initial begin
    repeat (3) @(negedge i_clk);
    i_resetn = 1'b1;
    repeat (3) @(negedge i_clk);
    expect_code(8'hf8);
    @(negedge i_clk);
    cpu_rd(8'hcd, rd_v);
    chk(rd_v, 8'h00);
    cpu_wr(8'hcc, 8'h8a);
    tick_gap();
    tick_gap();
    chk(8'(g), 8'h04);
    tsel = 1'b1;
    tick_gap();
    tick_gap();
    chk(8'(g), 8'h50);
    for (int k = 1; k < 17; k++) begin
      for (int v = 0; v < 2; v++) begin
        push_ev(bscr_pkg::bscr_event_e'(k[4:0]), !(v[0] && ack_kinds[k]),
                v[0] && arb_kinds[k]);
        wait_flag();
        exp_c = base[k] + ((v[0] && (ack_kinds[k] || arb_kinds[k])) ? 8'h08 : 8'h00);
        expect_code(exp_c);
        clr();
        expect_code(8'hf8);
      end
    end
    push_ev(bscr_pkg::BSCR_EV_START, 1'b1, 1'b0);
    wait_flag();
    for (int i = 0; i < 16; i++) push_ev(bscr_pkg::BSCR_EV_MTX, 1'b1, 1'b0);
    chk({7'h0, o_event_ready}, 8'h00);
    expect_code(8'h08);
    for (int i = 0; i < 16; i++) begin
      clr();
      wait_flag();
      expect_code(8'h28);
    end
    clr();
    repeat (4) @(negedge i_clk);
    expect_code(8'hf8);
    for (int s = 0; s < 2; s++) begin
      i_illegal_cond = 1'b1;
      @(negedge i_clk);
      i_illegal_cond = 1'b0;
      push_ev(bscr_pkg::BSCR_EV_START, 1'b1, 1'b0);
      repeat (3) @(negedge i_clk);
      expect_code(8'h00);
      i_stop_request_bit  = 1'b1;
      i_start_request_bit = s[0];
      clr();
      i_stop_request_bit  = 1'b0;
      i_start_request_bit = 1'b0;
      chk(o_bus_state_code, 8'hf8);
      chk({7'h0, o_bus_idle}, 8'h01);
      chk({7'h0, o_issue_start}, {7'h0, s[0]});
      wait_flag();
      expect_code(8'h08);
      clr();
    end
    push_ev(bscr_pkg::BSCR_EV_START, 1'b1, 1'b0);
    wait_flag();
    cpu_wr(8'hcd, 8'h5a);
    chk({7'h0, o_engine_reset}, 8'h01);
    chk({7'h0, o_interrupt_flag_bit}, 8'h00);
    chk(o_bus_state_code, 8'hf8);
    tsel = 1'b0;
    tick_gap();
    tick_gap();
    chk(8'(g), 8'h01);
    print_verdict();
  end
endmodule
